// ---- logic/dcw_top.sv ----
// Copy window logic: APB registers plus per-packet copy decision.
// Assumes packet headers arrive one per cycle with a valid strobe.
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
module dcw_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        is_port0_or_bridged,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_is_write,
  input  wire logic [1:0]  pkt_stn,
  input  wire logic [1:0]  pkt_port,
  input  wire logic [63:0] pkt_addr,
  output logic             fwd_valid,
  output logic      [63:0] fwd_addr,
  output logic             copy_valid,
  output logic      [63:0] copy_addr,
  output logic      [3:0]  copy_dst_port
);
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [11:0] base_lo_reg;
  logic [31:0] base_hi_reg;
  logic [11:0] xlat_lo_reg;
  logic [31:0] xlat_hi_reg;
  logic [11:0] setup_lo_reg;
  logic [31:0] setup_hi_reg;
  logic [8:0]  sel_reg;
  logic [1:0]  map_type;
  logic        wr_en;
  logic        hit_any;
  logic [31:0] rd_next;
  logic        sel_base_lo;
  logic        sel_base_hi;
  logic        sel_xlat_lo;
  logic        sel_xlat_hi;
  logic        sel_setup_lo;
  logic        sel_setup_hi;
  logic        sel_copy_sel;

  assign map_type = dcw_pkg::MAP_TYPE_64;
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite & is_port0_or_bridged;
  assign pslverr  = 1'b0;

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // Unmapped offsets and other ports read as zero
  always_comb begin
    hit_any = 1'b1;
    rd_next = dcw_pkg::RST_ZERO;
    if (!is_port0_or_bridged) begin
      hit_any = 1'b0;
    end else if (paddr == dcw_pkg::OFF_BASE_LO) begin
      rd_next = {base_lo_reg, 16'h0000, 4'h0} | dcw_pkg::RO_BIT3
              | {29'h0, map_type, 1'b0};
    end else if (paddr == dcw_pkg::OFF_BASE_HI) begin
      rd_next = base_hi_reg;
    end else if (paddr == dcw_pkg::OFF_XLAT_LO) begin
      rd_next = {xlat_lo_reg, 20'h00000};
    end else if (paddr == dcw_pkg::OFF_XLAT_HI) begin
      rd_next = (map_type == dcw_pkg::MAP_TYPE_64) ? xlat_hi_reg
                                                   : dcw_pkg::RST_ZERO;
    end else if (paddr == dcw_pkg::OFF_SETUP_LO) begin
      rd_next = {setup_lo_reg, 20'h00000};
    end else if (paddr == dcw_pkg::OFF_SETUP_HI) begin
      rd_next = (map_type == dcw_pkg::MAP_TYPE_64) ? setup_hi_reg
                                                   : dcw_pkg::RST_ZERO;
    end else if (paddr == dcw_pkg::OFF_SEL) begin
      rd_next = {23'h0, sel_reg};
    end else begin
      hit_any = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Read data register
  // ------------------------------------------------------------------
  // Latched at the setup edge so data stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= dcw_pkg::RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_any ? rd_next : dcw_pkg::RST_ZERO;
    end
  end

  // ------------------------------------------------------------------
  // Write address decode
  // ------------------------------------------------------------------
  always_comb begin
    sel_base_lo  = 1'b0;
    sel_base_hi  = 1'b0;
    sel_xlat_lo  = 1'b0;
    sel_xlat_hi  = 1'b0;
    sel_setup_lo = 1'b0;
    sel_setup_hi = 1'b0;
    sel_copy_sel = 1'b0;
    if (!wr_en) begin
      sel_base_lo = 1'b0;
    end else if (paddr == dcw_pkg::OFF_BASE_LO) begin
      sel_base_lo = 1'b1;
    end else if (paddr == dcw_pkg::OFF_BASE_HI) begin
      sel_base_hi = 1'b1;
    end else if (paddr == dcw_pkg::OFF_XLAT_LO) begin
      sel_xlat_lo = 1'b1;
    end else if (paddr == dcw_pkg::OFF_XLAT_HI) begin
      sel_xlat_hi = 1'b1;
    end else if (paddr == dcw_pkg::OFF_SETUP_LO) begin
      sel_setup_lo = 1'b1;
    end else if (paddr == dcw_pkg::OFF_SETUP_HI) begin
      sel_setup_hi = 1'b1;
    end else if (paddr == dcw_pkg::OFF_SEL) begin
      sel_copy_sel = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  // Window base low, address bits 31:20
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_lo_reg <= 12'h000;
    end else if (sel_base_lo) begin
      base_lo_reg <= pwdata[31:20];
    end
  end

  // Window base high, address bits 63:32
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_hi_reg <= dcw_pkg::RST_ZERO;
    end else if (sel_base_hi) begin
      base_hi_reg <= pwdata;
    end
  end

  // Translation base low, address bits 31:20
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xlat_lo_reg <= 12'h000;
    end else if (sel_xlat_lo) begin
      xlat_lo_reg <= pwdata[31:20];
    end
  end

  // Translation base high, only in 64-bit map mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xlat_hi_reg <= dcw_pkg::RST_ZERO;
    end else if (sel_xlat_hi && map_type == dcw_pkg::MAP_TYPE_64) begin
      xlat_hi_reg <= pwdata;
    end
  end

  // Window size mask low, address bits 31:20
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_lo_reg <= 12'h000;
    end else if (sel_setup_lo) begin
      setup_lo_reg <= pwdata[31:20];
    end
  end

  // Window size mask high and enable, only in 64-bit map mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_hi_reg <= dcw_pkg::RST_ZERO;
    end else if (sel_setup_hi && map_type == dcw_pkg::MAP_TYPE_64) begin
      setup_hi_reg <= pwdata;
    end
  end

  // Source port, station, destination and port enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= 9'h000;
    end else if (sel_copy_sel) begin
      sel_reg <= pwdata[8:0];
    end
  end

  // ------------------------------------------------------------------
  // Copy decision
  // ------------------------------------------------------------------
  logic        src_ok;
  logic        dst_ok;
  logic        in_win;
  logic [63:0] win_mask;
  logic [63:0] base_full;
  logic [63:0] xlat_full;
  logic [3:0]  dst;

  assign dst       = sel_reg[7:4];
  assign dst_ok    = dcw_pkg::DST_VALID_MAP[dst];
  assign win_mask  = {setup_hi_reg[30:0], 1'b1, setup_lo_reg, 20'h00000};
  assign base_full = {base_hi_reg, base_lo_reg, 20'h00000};
  assign xlat_full = {xlat_hi_reg, xlat_lo_reg, 20'h00000};
  assign in_win    = ((pkt_addr & win_mask) == (base_full & win_mask))
                   & setup_hi_reg[31];

  // ------------------------------------------------------------------
  // Source match
  // ------------------------------------------------------------------
  always_comb begin
    src_ok = (sel_reg[3:2] != dcw_pkg::STN_RESERVED)
           && (pkt_stn == sel_reg[3:2]);
    if (sel_reg[8]) begin
      src_ok = src_ok && (pkt_port == sel_reg[1:0]);
    end
    // Port field ignored with enable clear
  end

  // ------------------------------------------------------------------
  // Forward and copy outputs
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid     <= 1'b0;
      fwd_addr      <= 64'h0;
      copy_valid    <= 1'b0;
      copy_addr     <= 64'h0;
      copy_dst_port <= 4'h0;
    end else begin
      fwd_valid  <= pkt_valid;
      fwd_addr   <= pkt_addr;
      copy_valid <= pkt_valid & pkt_is_write & src_ok & dst_ok & in_win
                  & is_port0_or_bridged;
      copy_addr  <= (pkt_addr & ~win_mask) | (xlat_full & win_mask);
      copy_dst_port <= dst;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Register side
  chk_map_type: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && is_port0_or_bridged
      && paddr == dcw_pkg::OFF_BASE_LO)
      |=> prdata[2:1] == dcw_pkg::MAP_TYPE_64)
    else $error("map type not 64-bit");
  chk_hi_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_base_hi |=> base_hi_reg == $past(pwdata))
    else $error("base high not written");
  chk_xlat_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_xlat_hi |=> xlat_hi_reg == $past(pwdata))
    else $error("translation high not written");
  chk_setup_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_setup_hi |=> setup_hi_reg == $past(pwdata))
    else $error("setup high not written");
  chk_wr_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !is_port0_or_bridged)
      |=> $stable(sel_reg) && $stable(base_hi_reg))
    else $error("write taken on other port");
  chk_rd_blank: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && !is_port0_or_bridged)
      |=> prdata == dcw_pkg::RST_ZERO)
    else $error("read data on other port");

  // Window enable and source selection
  chk_copy_needs_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> $past(setup_hi_reg[31]))
    else $error("copy while off");
  chk_port_match: assert property (
    @(posedge pclk) disable iff (!presetn)
    (copy_valid && $past(sel_reg[8]))
      |-> $past(pkt_port) == $past(sel_reg[1:0]))
    else $error("copy from wrong port");
  chk_stn_match: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> $past(pkt_stn) == $past(sel_reg[3:2]))
    else $error("copy from wrong station");
  chk_stn_legal: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> $past(sel_reg[3:2]) != dcw_pkg::STN_RESERVED)
    else $error("copy from reserved station");

  // Destination
  chk_dst_legal: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> dcw_pkg::DST_VALID_MAP[copy_dst_port])
    else $error("reserved destination");
  chk_dst_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> copy_dst_port == $past(sel_reg[7:4]))
    else $error("wrong destination");

  // Forwarding and copying
  chk_fwd_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> fwd_valid && fwd_addr == $past(pkt_addr))
    else $error("original not forwarded");
  chk_fwd_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    fwd_valid == $past(pkt_valid))
    else $error("forward pulse lost");
  chk_copy_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> $past(pkt_valid && pkt_is_write))
    else $error("copy of a non-write");
  chk_copy_in_win: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> (($past(pkt_addr) ^ $past(base_full))
      & $past(win_mask)) == 64'h0)
    else $error("copy outside window");
  chk_copy_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid |-> ((copy_addr ^ $past(pkt_addr))
      & ~$past(win_mask)) == 64'h0)
    else $error("copy offset changed");
  chk_absent: assert property (
    @(posedge pclk) disable iff (!presetn)
    !is_port0_or_bridged |=> !copy_valid)
    else $error("copy on other port");

  // ------------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------------
  cov_copy: cover property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid);
  cov_port_mode: cover property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid && sel_reg[8]);
  cov_station_mode: cover property (
    @(posedge pclk) disable iff (!presetn)
    copy_valid && !$past(sel_reg[8]));
  cov_fwd_only: cover property (
    @(posedge pclk) disable iff (!presetn)
    fwd_valid && !copy_valid);
  cov_other_port: cover property (
    @(posedge pclk) disable iff (!presetn)
    fwd_valid && !is_port0_or_bridged);
endmodule
`default_nettype wire

// ---- logic/dcw_pkg.sv ----
// Constants for the fourth copy window and its source/destination selector.
// Assumes one core clock and an APB register slave in the same domain.
// Notes on behaviour
// - Low window register map type field reads 10b, a 64-bit window.
// - High window register holds base bits 63:32, writable, resets zero.
// - High translation register writable only with 64-bit map type.
// - High setup bit 31 enables the window; writable only in 64-bit mode.
// - Source port field counts only while source port enable is set.
// - Source station field picks ingress station 0, 1 or 2; 11b reserved.
// - Destination field names egress port 0,1,5,6,8 or 9; others reserved.
// - Enable clear: writes from any port of the chosen station are copied.
// - Enable set: only writes from the programmed source port are copied.
// - Registers exist only on port 0 or its bridged virtual side.
`default_nettype none
package dcw_pkg;
  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFF_BASE_LO  = 12'h4F8;
  localparam logic [11:0] OFF_BASE_HI  = 12'h4FC;
  localparam logic [11:0] OFF_XLAT_LO  = 12'h500;
  localparam logic [11:0] OFF_XLAT_HI  = 12'h504;
  localparam logic [11:0] OFF_SETUP_LO = 12'h508;
  localparam logic [11:0] OFF_SETUP_HI = 12'h50C;
  localparam logic [11:0] OFF_SEL      = 12'h510;
  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0]  MAP_TYPE_64   = 2'h2;
  localparam logic [1:0]  MAP_TYPE_32   = 2'h0;
  localparam int          MAP_LSB       = 1;
  localparam int          WIN_LSB       = 20;
  localparam int          WIN_W         = 12;
  localparam int          SETUP_EN_BIT  = 31;
  localparam int          SEL_PORT_LSB  = 0;
  localparam int          SEL_STN_LSB   = 2;
  localparam int          SEL_DST_LSB   = 4;
  localparam int          SEL_PEN_BIT   = 8;
  localparam logic [1:0]  STN_RESERVED  = 2'h3;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RO_BIT3       = 32'h0000_0008;
  // Valid destination port codes
  localparam logic [15:0] DST_VALID_MAP = 16'h0363;
endpackage
`default_nettype wire

// ---- tb/dcw_pkt_src.sv ----
// Packet header source standing in for the ingress link partners.
// Assumes the bench raises send for one clock per header.
`default_nettype none
module dcw_pkt_src (
  input  wire logic        pclk,
  input  wire logic        send,
  input  wire logic        wr,
  input  wire logic [1:0]  stn,
  input  wire logic [1:0]  port,
  input  wire logic [63:0] addr,
  output logic             pkt_valid,
  output logic             pkt_is_write,
  output logic      [1:0]  pkt_stn,
  output logic      [1:0]  pkt_port,
  output logic      [63:0] pkt_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Header fields hold the inverse of the inputs between headers so stale values never match
  always_ff @(posedge pclk) begin
    pkt_valid    <= send;
    pkt_is_write <= send ? wr : ~wr;
    pkt_stn      <= send ? stn : ~stn;
    pkt_port     <= send ? port : ~port;
    pkt_addr     <= send ? addr : ~addr;
  end
endmodule
`default_nettype wire

// ---- tb/tb_dual_cast_fourth_copy_window_and_source_select.sv ----
// Self-checking bench for the copy window block.
// Assumes an APB slave with zero wait states and one cycle packet latency.
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_dual_cast_fourth_copy_window_and_source_select;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] A  = 64'h0000_0001_1234_5678;
  localparam logic [63:0] CA = 64'h0000_0002_ABC4_5678;
  logic        pclk, presetn, port0, psel, penable, pwrite, pready, pslverr;
  logic        send, wr, pv, pw, fv, cv;
  logic [1:0]  st, pt, ps, pp;
  logic [3:0]  cd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] ad, pa, fa, ca;
  int          mismatches, checks_done, cyc;
  logic [3:0]  dsts [6] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h8, 4'h9};
  logic [3:0]  srcs [6] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h8, 4'h9};
  dcw_pkt_src u_dcw_pkt_src (.pclk(pclk), .send(send), .wr(wr), .stn(st),
    .port(pt), .addr(ad), .pkt_valid(pv), .pkt_is_write(pw), .pkt_stn(ps),
    .pkt_port(pp), .pkt_addr(pa));
  dcw_top u_dcw_top (.pclk(pclk), .presetn(presetn),
    .is_port0_or_bridged(port0), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_valid(pv), .pkt_is_write(pw),
    .pkt_stn(ps), .pkt_port(pp), .pkt_addr(pa), .fwd_valid(fv),
    .fwd_addr(fa), .copy_valid(cv), .copy_addr(ca), .copy_dst_port(cd));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict;
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    `CHK(pslverr, 1'b0)
    psel <= 0; penable <= 0;
  endtask
  task pkt(input logic [1:0] s, p, input logic w, input logic [63:0] a,
           input logic c, input logic [3:0] dst);
    @(posedge pclk);
    send <= 1; st <= s; pt <= p; wr <= w; ad <= a;
    @(posedge pclk);
    send <= 0;
    @(posedge pclk);
    #1;
    `CHK(fv, 1'b1) `CHK(fa, a) `CHK(cv, c)
    if (c) begin
      `CHK(ca, CA) `CHK(cd, dst)
    end
  endtask
  task t_regs;
    apb(0, 12'h4F8, 0); `CHK(rd, 32'h0000_000C)
    for (int i = 0; i < 7; i++) begin
      apb(0, 12'h4FC + 12'(4 * i), 0); `CHK(rd, 32'h0)
    end
    apb(1, 12'h4F8, 32'hFFFF_FFFF); apb(0, 12'h4F8, 0);
    `CHK(rd, 32'hFFF0_000C)
    apb(1, 12'h4FC, 32'hA5A5_5A5A); apb(0, 12'h4FC, 0);
    `CHK(rd, 32'hA5A5_5A5A)
    apb(1, 12'h504, 32'h2); apb(0, 12'h504, 0); `CHK(rd, 32'h2)
    apb(1, 12'h50C, 32'hFFFF_FFFF); apb(0, 12'h50C, 0);
    `CHK(rd, 32'hFFFF_FFFF)
  endtask
  task t_copy;
    apb(1, 12'h4F8, 32'h1230_0000); apb(1, 12'h4FC, 32'h1);
    apb(1, 12'h500, 32'hABC0_0000); apb(1, 12'h508, 32'hFFF0_0000);
    apb(1, 12'h510, 32'h55); pkt(1, 2, 1, A, 1, 5);
    pkt(1, 2, 0, A, 0, 5); pkt(0, 2, 1, A, 0, 5);
    pkt(1, 1, 1, A ^ 64'h1000_0000, 0, 5);
    apb(1, 12'h510, 32'h155); pkt(1, 2, 1, A, 0, 5);
    pkt(1, 1, 1, A, 1, 5);
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h510, {23'h0, 1'b1, dsts[i], srcs[i]});
      pkt(srcs[i][3:2], srcs[i][1:0], 1, A, 1, dsts[i]);
    end
    apb(1, 12'h510, 32'h25); pkt(1, 1, 1, A, 0, 2);
    apb(1, 12'h510, 32'h5D); pkt(3, 1, 1, A, 0, 5);
    apb(1, 12'h510, 32'h55); apb(1, 12'h50C, 32'h7FFF_FFFF);
    pkt(1, 1, 1, A, 0, 5);
    apb(1, 12'h50C, 32'hFFFF_FFFF);
    port0 <= 0; apb(0, 12'h4F8, 0); `CHK(rd, 32'h0)
    pkt(1, 1, 1, A, 0, 5);
  endtask
  initial begin
    presetn = 0; port0 = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; send = 0; wr = 0; st = 0; pt = 0; ad = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_copy;
    print_verdict;
  end
endmodule
`default_nettype wire
